// [core/rtc_pkg.sv]
// constants, field layouts and carrier types of the calendar, trim and
// weekly alarm block; assumes a 250 MHz core clock and a 32.768 kHz osc.
//
// What this block does
// - seconds advance once per 32768 oscillator pulses normally
// - trim acts only on seconds starting at 00, 20 or 40
// - writing the trim bits with bit 7 clear arms trimming with the new value
// - trim written during a correction second skips that second's correction
// - direction 0 lengthens the second by (magnitude - 1) x 2 pulses
// - direction 1 shortens the second by (inverted magnitude + 1) x 2
// - magnitude bits 5..1 all zero means no correction at all
// - oscillator-stop rising clears the whole trim register
// - day-of-month is BCD in bits 5..0, bits 7..6 read zero
// - month has century in bit 7, BCD month bits 4..0, 6..5 zero
// - year is a full eight-bit BCD value, all bits read/write
// - after oscillator stop date/alarm undefined, fixed-zero bits still zero
// - alarm minute is BCD in bits 6..0, bit 7 reads zero
// - alarm hour sits in bits 5..0, bits 7..6 read zero
// - alarm hour bit 5 is pm flag or hour-tens twenty
// - twelve-hour midnight is 12, noon 32; compared in that code
// - day mask bits 0..6 map weekday values 0..6, bit 7 zero
// - all mask bits zero means weekly alarm never fires
// - enabled flag sets about 61 us after match, drives interrupt low
// - year 99 to 00 toggles century; leap years divide by four
// - day wraps after month length and carries to month, then year
package rtc_pkg;

  // register addresses on the serial link
  localparam logic [3:0] ADDR_DAY   = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR  = 4'h6;
  localparam logic [3:0] ADDR_TRIM  = 4'h7;
  localparam logic [3:0] ADDR_WMIN  = 4'h8;
  localparam logic [3:0] ADDR_WHOUR = 4'h9;
  localparam logic [3:0] ADDR_WMASK = 4'ha;

  // writable bits per register; the rest read as zero
  localparam logic [7:0] DAY_MASK   = 8'h3f;
  localparam logic [7:0] MONTH_MASK = 8'h9f;
  localparam logic [7:0] YEAR_MASK  = 8'hff;
  localparam logic [7:0] TRIM_MASK  = 8'h7f;
  localparam logic [7:0] WMIN_MASK  = 8'h7f;
  localparam logic [7:0] WHOUR_MASK = 8'h3f;
  localparam logic [7:0] WMASK_MASK = 8'h7f;

  // field positions
  localparam int TRIM_LOCK_BIT = 7;
  localparam int TRIM_DIR_BIT  = 6;
  localparam int CENTURY_BIT   = 7;
  localparam int FMT_ONE_BIT   = 3;
  localparam int FMT_READ_BIT  = 2;

  // reset values
  localparam logic [7:0] DAY_RST   = 8'h01;
  localparam logic [7:0] MONTH_RST = 8'h01;
  localparam logic [7:0] YEAR_RST  = 8'h00;
  localparam logic [7:0] TRIM_RST  = 8'h00;
  localparam logic [7:0] ALARM_RST = 8'h00;

  // calendar values in bcd
  localparam logic [7:0] SEC_00  = 8'h00;
  localparam logic [7:0] SEC_20  = 8'h20;
  localparam logic [7:0] SEC_40  = 8'h40;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] MON_DEC = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;

  // timing
  localparam logic [16:0] SEC_OSC_CYCLES  = 17'h08000;
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          ALARM_DELAY_US  = 61;
  localparam int          ALARM_DELAY_CYC =
    (ALARM_DELAY_US * 1000000) / CLK_PERIOD_PS;
  localparam int          SYNC_W          = 3;

  // write request carried from the link to the core
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } rtc_wr_req_t;

  // register image handed to the link for reads
  typedef struct packed {
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] trim;
    logic [7:0] wmin;
    logic [7:0] whour;
    logic [7:0] wmask;
  } rtc_regs_t;

  typedef enum logic [1:0] {
    RTC_LK_CMD  = 2'b01,
    RTC_LK_DATA = 2'b10
  } rtc_link_state_t;

endpackage

// [core/rtc_cal_trim.sv]
// calendar counters, timekeeping trim and weekly alarm behind a
// three-wire serial link; link logic runs on sclk, its frame state is cleared by ce low.
// assumes time counters outside feed minute, hour, weekday and day carry.
`timescale 1ns/10ps
`default_nettype none

module rtc_cal_trim #(
  parameter int unsigned ALARM_DELAY_CYC = rtc_pkg::ALARM_DELAY_CYC
) (
  // core clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // oscillator pulses and oscillator-stop status
  input  wire logic       osc_i,
  input  wire logic       osc_stop_flag_i,
  // current time from the time counters
  input  wire logic [7:0] cur_minute_i,
  input  wire logic [7:0] cur_hour_i,
  input  wire logic [2:0] cur_weekday_i,
  input  wire logic       day_carry_i,
  // weekly alarm control bits
  input  wire logic       weekly_alarm_enable_i,
  input  wire logic       weekly_alarm_clear_i,
  // three-wire link
  input  wire logic       sclk_i,
  input  wire logic       ce_i,
  input  wire logic       sio_i,
  output logic            sio_o,
  output logic            sio_oe_o,
  // status
  output logic            second_tick_o,
  output logic [7:0]      seconds_o,
  output logic            weekly_alarm_flag_o,
  output logic            interrupt_out_n_o
);

  localparam int DW = $clog2(ALARM_DELAY_CYC + 1);

  // ---------------- link domain ----------------
  rtc_pkg::rtc_link_state_t lk_state_ff;
  logic [2:0]               lk_bit_ff;
  logic [6:0]               lk_shift_ff;
  logic [3:0]               lk_addr_ff;
  logic                     lk_one_ff;
  logic                     lk_read_ff;
  logic [7:0]               lk_rd_ff;
  rtc_pkg::rtc_wr_req_t     lk_wr_ff;
  logic                     lk_wr_tgl_ff;
  logic [7:0]               lk_byte;
  rtc_pkg::rtc_regs_t       snap_ff;

  assign lk_byte = {lk_shift_ff, sio_i};

  function automatic logic [7:0] read_byte(input logic [3:0] a,
                                           input rtc_pkg::rtc_regs_t r);
    case (a)
      rtc_pkg::ADDR_DAY:   read_byte = r.day;
      rtc_pkg::ADDR_MONTH: read_byte = r.month;
      rtc_pkg::ADDR_YEAR:  read_byte = r.year;
      rtc_pkg::ADDR_TRIM:  read_byte = r.trim;
      rtc_pkg::ADDR_WMIN:  read_byte = r.wmin;
      rtc_pkg::ADDR_WHOUR: read_byte = r.whour;
      rtc_pkg::ADDR_WMASK: read_byte = r.wmask;
      default:             read_byte = 8'h00;
    endcase
  endfunction

  // frame parse; ce low ends the frame since sclk may stop outside it
  always_ff @(posedge sclk_i or negedge ce_i)
  begin
    if (!ce_i)
    begin
      lk_state_ff  <= rtc_pkg::RTC_LK_CMD;
      lk_bit_ff    <= 3'h0;
      lk_shift_ff  <= 7'h00;
      lk_addr_ff   <= 4'h0;
      lk_one_ff    <= 1'b0;
      lk_read_ff   <= 1'b0;
      lk_rd_ff     <= 8'h00;
    end
    else
    begin
      lk_shift_ff <= lk_byte[6:0];
      lk_bit_ff   <= lk_bit_ff + 3'h1;
      lk_rd_ff    <= {lk_rd_ff[6:0], 1'b0};
      if (lk_bit_ff == 3'h7)
      begin
        case (lk_state_ff)
          rtc_pkg::RTC_LK_CMD:
          begin
            lk_addr_ff  <= lk_byte[7:4];
            lk_one_ff   <= lk_byte[rtc_pkg::FMT_ONE_BIT];
            lk_read_ff  <= lk_byte[rtc_pkg::FMT_READ_BIT];
            lk_state_ff <= rtc_pkg::RTC_LK_DATA;
            lk_rd_ff    <= read_byte(lk_byte[7:4], snap_ff);
          end
          rtc_pkg::RTC_LK_DATA:
          begin
            lk_addr_ff <= lk_addr_ff + 4'h1;
            if (lk_one_ff)
              lk_state_ff <= rtc_pkg::RTC_LK_CMD;
            else if (lk_read_ff)
              lk_rd_ff <= read_byte(lk_addr_ff + 4'h1, snap_ff);
          end
          default:
            lk_state_ff <= rtc_pkg::RTC_LK_CMD;
        endcase
      end
    end
  end

  // toggle and payload survive ce low so no write is lost or repeated;
  // srst only lands while the link is idle, sclk may be stopped then
  always_ff @(posedge sclk_i or posedge srst_i)
  begin
    if (srst_i)
    begin
      lk_wr_tgl_ff <= 1'b0;
      lk_wr_ff     <= '0;
    end
    else if (ce_i && lk_bit_ff == 3'h7 && !lk_read_ff &&
             lk_state_ff == rtc_pkg::RTC_LK_DATA)
    begin
      lk_wr_tgl_ff <= ~lk_wr_tgl_ff;
      lk_wr_ff     <= '{addr: lk_addr_ff, data: lk_byte};
    end
  end

  // read data leaves on the falling edge, host samples on rising
  always_ff @(negedge sclk_i or negedge ce_i)
  begin
    if (!ce_i)
    begin
      sio_o    <= 1'b0;
      sio_oe_o <= 1'b0;
    end
    else
    begin
      sio_o    <= lk_rd_ff[7];
      sio_oe_o <= (lk_state_ff == rtc_pkg::RTC_LK_DATA) && lk_read_ff;
    end
  end

  // ---------------- core domain ----------------
  logic [rtc_pkg::SYNC_W-1:0] sy_in;
  logic [rtc_pkg::SYNC_W-1:0] sy1_ff;
  logic [rtc_pkg::SYNC_W-1:0] sy2_ff;
  logic [rtc_pkg::SYNC_W-1:0] sy3_ff;
  logic [rtc_pkg::SYNC_W-1:0] sy_ok_ff;
  logic [rtc_pkg::SYNC_W-1:0] sy_prev_ff;
  logic [rtc_pkg::SYNC_W-1:0] sy_agree;
  logic                       osc_tick;
  logic                       ce_core;
  logic                       wr_evt;

  assign sy_in    = {lk_wr_tgl_ff, ce_i, osc_i};
  assign sy_agree = ~(sy2_ff ^ sy3_ff);
  assign osc_tick = sy_ok_ff[0] & ~sy_prev_ff[0];
  assign ce_core  = sy_ok_ff[1];
  assign wr_evt   = sy_ok_ff[2] ^ sy_prev_ff[2];

  // change counts only once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sy1_ff     <= '0;
      sy2_ff     <= '0;
      sy3_ff     <= '0;
      sy_ok_ff   <= '0;
      sy_prev_ff <= '0;
    end
    else
    begin
      sy1_ff     <= sy_in;
      sy2_ff     <= sy1_ff;
      sy3_ff     <= sy2_ff;
      sy_ok_ff   <= (sy_ok_ff & ~sy_agree) | (sy3_ff & sy_agree);
      sy_prev_ff <= sy_ok_ff;
    end
  end

  // write request fields are stable long before the toggle arrives
  logic wr_day;
  logic wr_month;
  logic wr_year;
  logic wr_trim;
  logic wr_wmin;
  logic wr_whour;
  logic wr_wmask;
  assign wr_day   = wr_evt && lk_wr_ff.addr == rtc_pkg::ADDR_DAY;
  assign wr_month = wr_evt && lk_wr_ff.addr == rtc_pkg::ADDR_MONTH;
  assign wr_year  = wr_evt && lk_wr_ff.addr == rtc_pkg::ADDR_YEAR;
  assign wr_trim  = wr_evt && lk_wr_ff.addr == rtc_pkg::ADDR_TRIM &&
                    !lk_wr_ff.data[rtc_pkg::TRIM_LOCK_BIT];
  assign wr_wmin  = wr_evt && lk_wr_ff.addr == rtc_pkg::ADDR_WMIN;
  assign wr_whour = wr_evt && lk_wr_ff.addr == rtc_pkg::ADDR_WHOUR;
  assign wr_wmask = wr_evt && lk_wr_ff.addr == rtc_pkg::ADDR_WMASK;

  // ---- second timing and trim ----
  logic [16:0] osc_cnt_ff;
  logic [7:0]  trim_ff;
  logic        trim_armed_ff;
  logic        trim_skip_ff;
  logic        osc_stop_d_ff;
  logic        corr_sec;
  logic        trim_null;
  logic        trim_on;
  logic [16:0] trim_up;
  logic [16:0] trim_dn;
  logic [16:0] sec_len;
  logic        sec_end;
  logic        osc_stop_rise;

  assign corr_sec = seconds_o == rtc_pkg::SEC_00 ||
                    seconds_o == rtc_pkg::SEC_20 ||
                    seconds_o == rtc_pkg::SEC_40;
  assign trim_null = trim_ff[5:1] == 5'h00;
  assign trim_on   = corr_sec && trim_armed_ff && !trim_skip_ff &&
                     !trim_null;
  assign trim_up   = {10'h000, trim_ff[5:0] - 6'h01, 1'b0};
  assign trim_dn   = {10'h000, ~trim_ff[5:0] + 6'h01, 1'b0};
  assign sec_len   = !trim_on ? rtc_pkg::SEC_OSC_CYCLES :
                     trim_ff[rtc_pkg::TRIM_DIR_BIT] ?
                     rtc_pkg::SEC_OSC_CYCLES - trim_dn :
                     rtc_pkg::SEC_OSC_CYCLES + trim_up;
  // at or past the end: a trim change mid-second must not overrun
  assign sec_end   = osc_tick &&
                     osc_cnt_ff >= sec_len - 17'h00001;
  assign osc_stop_rise = osc_stop_flag_i && !osc_stop_d_ff;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      osc_cnt_ff    <= 17'h00000;
      seconds_o     <= rtc_pkg::SEC_00;
      second_tick_o <= 1'b0;
    end
    else
    begin
      second_tick_o <= sec_end;
      if (sec_end)
      begin
        osc_cnt_ff <= 17'h00000;
        seconds_o  <= (seconds_o == rtc_pkg::SEC_MAX) ? rtc_pkg::SEC_00 :
                      bcd_inc(seconds_o);
      end
      else if (osc_tick)
        osc_cnt_ff <= osc_cnt_ff + 17'h00001;
    end
  end

  // stop flag wins over a write landing in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      trim_ff       <= rtc_pkg::TRIM_RST;
      trim_armed_ff <= 1'b0;
      trim_skip_ff  <= 1'b0;
      osc_stop_d_ff <= 1'b0;
    end
    else
    begin
      osc_stop_d_ff <= osc_stop_flag_i;
      if (osc_stop_rise)
      begin
        trim_ff       <= rtc_pkg::TRIM_RST;
        trim_armed_ff <= 1'b0;
        trim_skip_ff  <= 1'b0;
      end
      else if (wr_trim)
      begin
        trim_ff       <= lk_wr_ff.data & rtc_pkg::TRIM_MASK;
        trim_armed_ff <= 1'b1;
        trim_skip_ff  <= corr_sec;
      end
      else if (sec_end)
        trim_skip_ff <= 1'b0;
    end
  end

  // ---- calendar ----
  logic [7:0] day_ff;
  logic [7:0] month_ff;
  logic [7:0] year_ff;
  logic       leap;
  logic [7:0] last_day;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // year 00 counts as leap; the century bit is not consulted
  assign leap = year_ff[4] ? (year_ff[3:0] == 4'h2 || year_ff[3:0] == 4'h6)
              : (year_ff[3:0] == 4'h0 || year_ff[3:0] == 4'h4 ||
                 year_ff[3:0] == 4'h8);

  always_comb
  begin
    case (month_ff[4:0])
      rtc_pkg::MON_FEB[4:0]: last_day = leap ? rtc_pkg::DAYS_29 :
                                               rtc_pkg::DAYS_28;
      rtc_pkg::MON_APR[4:0],
      rtc_pkg::MON_JUN[4:0],
      rtc_pkg::MON_SEP[4:0],
      rtc_pkg::MON_NOV[4:0]: last_day = rtc_pkg::DAYS_30;
      default:               last_day = rtc_pkg::DAYS_31;
    endcase
  end

  // a link write beats a carry in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      day_ff   <= rtc_pkg::DAY_RST;
      month_ff <= rtc_pkg::MONTH_RST;
      year_ff  <= rtc_pkg::YEAR_RST;
    end
    else
    begin
      if (wr_day)
        day_ff <= lk_wr_ff.data & rtc_pkg::DAY_MASK;
      else if (day_carry_i)
        day_ff <= (day_ff == last_day) ? rtc_pkg::DAY_RST :
                  bcd_inc(day_ff);
      if (wr_month)
        month_ff <= lk_wr_ff.data & rtc_pkg::MONTH_MASK;
      else if (day_carry_i && day_ff == last_day)
      begin
        if (month_ff[4:0] == rtc_pkg::MON_DEC[4:0])
          month_ff[4:0] <= rtc_pkg::MONTH_RST[4:0];
        else
          month_ff[4:0] <= 5'(bcd_inc({3'h0, month_ff[4:0]}));
        if (month_ff[4:0] == rtc_pkg::MON_DEC[4:0] &&
            year_ff == rtc_pkg::YEAR_MAX)
          month_ff[rtc_pkg::CENTURY_BIT] <=
            ~month_ff[rtc_pkg::CENTURY_BIT];
      end
      if (wr_year)
        year_ff <= lk_wr_ff.data & rtc_pkg::YEAR_MASK;
      else if (day_carry_i && day_ff == last_day &&
               month_ff[4:0] == rtc_pkg::MON_DEC[4:0])
        year_ff <= (year_ff == rtc_pkg::YEAR_MAX) ? 8'h00 :
                   bcd_inc(year_ff);
    end
  end

  // ---- weekly alarm ----
  logic [7:0]    wmin_ff;
  logic [7:0]    whour_ff;
  logic [7:0]    wmask_ff;
  logic          match;
  logic          match_d_ff;
  logic          dly_run_ff;
  logic [DW-1:0] dly_cnt_ff;
  logic          flag_set;
  logic          nxt_flag;

  // stored bits already masked, so fixed-zero bits read zero
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wmin_ff  <= rtc_pkg::ALARM_RST;
      whour_ff <= rtc_pkg::ALARM_RST;
      wmask_ff <= rtc_pkg::ALARM_RST;
    end
    else
    begin
      if (wr_wmin)
        wmin_ff <= lk_wr_ff.data & rtc_pkg::WMIN_MASK;
      if (wr_whour)
        whour_ff <= lk_wr_ff.data & rtc_pkg::WHOUR_MASK;
      if (wr_wmask)
        wmask_ff <= lk_wr_ff.data & rtc_pkg::WMASK_MASK;
    end
  end

  // hour compared raw: 12/32 twelve-hour code matches as stored
  // weekday 7 indexes the always-zero bit 7, so it never matches
  assign match = cur_minute_i[6:0] == wmin_ff[6:0] &&
                 cur_hour_i[5:0] == whour_ff[5:0] &&
                 wmask_ff[cur_weekday_i];
  assign flag_set = dly_run_ff &&
                    dly_cnt_ff == DW'(ALARM_DELAY_CYC - 1);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      match_d_ff <= 1'b0;
      dly_run_ff <= 1'b0;
      dly_cnt_ff <= '0;
    end
    else
    begin
      match_d_ff <= match;
      if (!weekly_alarm_enable_i || flag_set)
        dly_run_ff <= 1'b0;
      else if (match && !match_d_ff)
      begin
        dly_run_ff <= 1'b1;
        dly_cnt_ff <= '0;
      end
      else if (dly_run_ff)
        dly_cnt_ff <= dly_cnt_ff + DW'(1);
    end
  end

  // set beats clear; disabled alarm reads zero
  always_comb
  begin
    if (!weekly_alarm_enable_i)
      nxt_flag = 1'b0;
    else if (flag_set)
      nxt_flag = 1'b1;
    else if (weekly_alarm_clear_i)
      nxt_flag = 1'b0;
    else
      nxt_flag = weekly_alarm_flag_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      weekly_alarm_flag_o <= 1'b0;
      interrupt_out_n_o   <= 1'b1;
    end
    else
    begin
      weekly_alarm_flag_o <= nxt_flag;
      interrupt_out_n_o   <= ~nxt_flag;
    end
  end

  // read image frozen while a frame is open so link reads stay stable
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      snap_ff <= '0;
    else if (!ce_core)
    begin
      snap_ff.day   <= day_ff;
      snap_ff.month <= month_ff;
      snap_ff.year  <= year_ff;
      snap_ff.trim  <= trim_ff;
      snap_ff.wmin  <= wmin_ff;
      snap_ff.whour <= whour_ff;
      snap_ff.wmask <= wmask_ff;
    end
  end

endmodule

`default_nettype wire

// [test/rtc_cal_trim_monitor.sv]
// weekly alarm and status checks on the block's ports
// assumes a bind from the bench top; one clk domain
`timescale 1ns/10ps
`default_nettype none
module rtc_mon #(
  parameter int unsigned ALARM_DELAY_CYC = 20
) (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       srst_i,
  // current time and alarm control
  input wire logic [7:0] cur_minute_i,
  input wire logic [7:0] cur_hour_i,
  input wire logic [2:0] cur_weekday_i,
  input wire logic       weekly_alarm_enable_i,
  input wire logic       weekly_alarm_clear_i,
  // status
  input wire logic       second_tick_o,
  input wire logic [7:0] seconds_o,
  input wire logic       weekly_alarm_flag_o,
  input wire logic       interrupt_out_n_o
);
  logic [18:0] prev_ff;
  logic [15:0] calm_ff;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      prev_ff <= '0;
    else
      prev_ff <= {cur_minute_i, cur_hour_i, cur_weekday_i};
  end

  // cycles of steady time with enable high; saturates, never wraps
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !weekly_alarm_enable_i ||
        prev_ff != {cur_minute_i, cur_hour_i, cur_weekday_i})
      calm_ff <= '0;
    else if (calm_ff != 16'hffff)
      calm_ff <= calm_ff + 16'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_flag_up;
    !weekly_alarm_flag_o ##1 weekly_alarm_flag_o;
  endsequence

  a_int_tracks_flag: assert property (
    interrupt_out_n_o == !weekly_alarm_flag_o)
    else $error("interrupt out of step with flag");
  a_flag_waits_delay: assert property (
    s_flag_up |-> calm_ff >= ALARM_DELAY_CYC - 1)
    else $error("flag set before the alarm delay");
  a_flag_no_wd7: assert property (
    s_flag_up |-> cur_weekday_i != 3'h7)
    else $error("flag set on weekday seven");
  a_enable_low_off: assert property (
    !weekly_alarm_enable_i |=> !weekly_alarm_flag_o)
    else $error("flag high with enable low");
  a_flag_holds: assert property (
    weekly_alarm_flag_o && weekly_alarm_enable_i && !weekly_alarm_clear_i
    |=> weekly_alarm_flag_o)
    else $error("flag dropped by itself");
  a_clear_drops: assert property (
    weekly_alarm_clear_i && calm_ff > ALARM_DELAY_CYC + 2
    |=> !weekly_alarm_flag_o)
    else $error("clear did not drop flag");
  a_no_refire: assert property (
    !weekly_alarm_flag_o && calm_ff > ALARM_DELAY_CYC + 2
    |=> !weekly_alarm_flag_o)
    else $error("flag set without a new match");
  a_tick_moves_sec: assert property (
    $changed(seconds_o) |-> second_tick_o)
    else $error("seconds moved without a tick");
  a_seconds_bcd: assert property (
    seconds_o[3:0] <= 4'h9 && seconds_o <= 8'h59)
    else $error("seconds not valid bcd");
  a_reset_defaults: assert property (
    $fell(srst_i) |-> !weekly_alarm_flag_o && seconds_o == 8'h00)
    else $error("status not at reset value");
endmodule
`default_nettype wire

// [test/rtc_host.sv]
// host side of the three-wire link: single-byte reads and writes
// assumes sclk rests high between frames; device samples sio on rise
`timescale 1ns/10ps
`default_nettype none
module rtc_host (
  // link out
  output logic sclk_o,
  output logic ce_o,
  output logic sio_o,
  // resolved data line
  input  wire logic sio_i
);
  localparam int HALF = 24;

  initial
  begin
    sclk_o = 1'b1;
    ce_o = 1'b0;
    sio_o = 1'b0;
  end

  task automatic shift(input logic [7:0] b, input bit rd,
                       output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      #HALF sclk_o = 1'b0;
      // while released, toggle so a stale bit never reads as data
      sio_o = rd ? ~sio_o : b[i];
      #HALF sclk_o = 1'b1;
      q[i] = sio_i;
    end
  endtask

  task automatic frame(input logic [3:0] a, input logic [3:0] f,
                       input logic [7:0] d, output logic [7:0] q);
    logic [7:0] c;
    ce_o = 1'b1;
    // read image freezes at ce rise; give the core time
    #100;
    shift({a, f}, 1'b0, c);
    shift(d, f[2], q);
    #HALF ce_o = 1'b0;
    #200;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input bit raw);
    logic [7:0] q;
    if (a == 4'h7 && !raw)
      d[7] = 1'b0;
    frame(a, 4'h8, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    frame(a, 4'hc, 8'h00, q);
  endtask
endmodule
`default_nettype wire

// [test/rtc_cal_trim_tb.sv]
// self-checking bench: registers over the link, calendar carry, alarm
// assumes rtc_host on the link and rtc_mon bound below
`timescale 1ns/10ps
`default_nettype none
module rtc_cal_trim_tb;
  localparam int unsigned DLY = 20;
  logic       clk_i, srst_i, osc_i, osc_stop_flag_i, day_carry_i;
  logic [7:0] cur_minute_i, cur_hour_i, q, d, secs;
  logic [2:0] cur_weekday_i;
  logic       en, clr, sclk, ce, sio_h, sio_d, sio_oe, sio_w;
  logic       tick, flag, int_n;
  int         miscompares, checks, seed;
  logic [47:0] cal [4] = '{48'h311299018100, 48'h280204290204,
                           48'h280203010303, 48'h300420010520};
  logic [7:0]  hrs [4] = '{8'h12, 8'h32, 8'h23, 8'h11};

  assign sio_w = sio_oe ? sio_d : sio_h;

  rtc_host host (.sclk_o(sclk), .ce_o(ce), .sio_o(sio_h), .sio_i(sio_w));

  rtc_cal_trim #(.ALARM_DELAY_CYC(DLY)) uut (
    .clk_i(clk_i), .srst_i(srst_i), .osc_i(osc_i),
    .osc_stop_flag_i(osc_stop_flag_i), .cur_minute_i(cur_minute_i),
    .cur_hour_i(cur_hour_i), .cur_weekday_i(cur_weekday_i),
    .day_carry_i(day_carry_i), .weekly_alarm_enable_i(en),
    .weekly_alarm_clear_i(clr), .sclk_i(sclk), .ce_i(ce),
    .sio_i(sio_w), .sio_o(sio_d), .sio_oe_o(sio_oe),
    .second_tick_o(tick), .seconds_o(secs),
    .weekly_alarm_flag_o(flag), .interrupt_out_n_o(int_n));

  function automatic logic [7:0] mask_of(input logic [3:0] a);
    case (a)
      rtc_pkg::ADDR_DAY:   return rtc_pkg::DAY_MASK;
      rtc_pkg::ADDR_MONTH: return rtc_pkg::MONTH_MASK;
      rtc_pkg::ADDR_YEAR:  return rtc_pkg::YEAR_MASK;
      rtc_pkg::ADDR_TRIM:  return rtc_pkg::TRIM_MASK;
      rtc_pkg::ADDR_WMIN:  return rtc_pkg::WMIN_MASK;
      rtc_pkg::ADDR_WHOUR: return rtc_pkg::WHOUR_MASK;
      rtc_pkg::ADDR_WMASK: return rtc_pkg::WMASK_MASK;
      default:             return 8'h00;
    endcase
  endfunction

  task automatic cmp_reg(input string n, input logic [7:0] e,
                         input logic [7:0] s);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic s);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", n, e, s);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // oscillator kept off the clk edges
  initial
  begin
    osc_i = 1'b0;
    #1;
    forever #32 osc_i = ~osc_i;
  end

  initial
  begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end

  initial
  begin
    seed = 32'hc5a75142;
    {srst_i, osc_stop_flag_i, day_carry_i, en, clr} = 5'b10000;
    {cur_minute_i, cur_hour_i, cur_weekday_i} = {8'h7f, 8'h00, 3'h0};
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int a = 4; a <= 11; a++)
    begin
      host.rd(a[3:0], q);
      cmp_reg("reset value", (a == 4 || a == 5) ? 8'h01 : 8'h00, q);
    end
    repeat (2)
      for (int a = 4; a <= 11; a++)
      begin
        d = 8'($random(seed));
        host.wr(a[3:0], d, 1'b0);
        host.rd(a[3:0], q);
        if (a == 7)
          d[7] = 1'b0;
        cmp_reg("field mask", d & mask_of(a[3:0]), q);
      end
    host.wr(rtc_pkg::ADDR_TRIM, 8'h3c, 1'b0);
    host.wr(rtc_pkg::ADDR_TRIM, 8'hc1, 1'b1);
    host.rd(rtc_pkg::ADDR_TRIM, q);
    cmp_reg("trim kept", 8'h3c, q);
    @(posedge clk_i) osc_stop_flag_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    osc_stop_flag_i <= 1'b0;
    host.rd(rtc_pkg::ADDR_TRIM, q);
    cmp_reg("trim after stop", 8'h00, q);
    foreach (cal[i])
    begin
      for (int k = 0; k < 3; k++)
        host.wr(4'h4 + k[3:0], cal[i][47 - 8 * k -: 8], 1'b0);
      @(posedge clk_i) day_carry_i <= 1'b1;
      @(posedge clk_i) day_carry_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (int k = 0; k < 3; k++)
      begin
        host.rd(4'h4 + k[3:0], q);
        cmp_reg("calendar carry", cal[i][23 - 8 * k -: 8], q);
      end
    end
    host.frame(rtc_pkg::ADDR_YEAR, 4'h0, 8'h42, q);
    host.frame(rtc_pkg::ADDR_YEAR, 4'h4, 8'h00, q);
    cmp_reg("burst year", 8'h42, q);
    for (int i = 0; i < 10; i++)
    begin
      logic [7:0] mn, hr, mk;
      logic [2:0] wd;
      logic       hit;
      mn = {1'b0, 3'($unsigned($random(seed)) % 6),
            4'($unsigned($random(seed)) % 10)};
      hr = hrs[i % 4];
      wd = (i == 8) ? 3'h7 : 3'($unsigned($random(seed)) % 7);
      mk = (i == 9) ? 8'h00 : 8'($random(seed)) & 8'h7f;
      if (i < 4)
        mk[wd] = 1'b1;
      hit = wd != 3'h7 && mk[wd];
      host.wr(rtc_pkg::ADDR_WMIN, mn, 1'b0);
      host.wr(rtc_pkg::ADDR_WHOUR, hr, 1'b0);
      host.wr(rtc_pkg::ADDR_WMASK, mk, 1'b0);
      @(posedge clk_i);
      en <= 1'b1;
      {cur_minute_i, cur_hour_i, cur_weekday_i} <= {mn, hr, wd};
      repeat (DLY - 1) @(posedge clk_i);
      cmp_bit("early flag", 1'b0, flag);
      repeat (8) @(posedge clk_i);
      cmp_bit("alarm flag", hit, flag);
      cmp_bit("interrupt", !hit, int_n);
      clr <= 1'b1;
      @(posedge clk_i) clr <= 1'b0;
      repeat (2) @(posedge clk_i);
      cmp_bit("flag cleared", 1'b0, flag);
      en <= 1'b0;
      cur_minute_i <= 8'h7f;
    end
    end_sim();
  end
endmodule

bind rtc_cal_trim rtc_mon #(.ALARM_DELAY_CYC(ALARM_DELAY_CYC)) mon (
  .clk_i(clk_i), .srst_i(srst_i), .cur_minute_i(cur_minute_i),
  .cur_hour_i(cur_hour_i), .cur_weekday_i(cur_weekday_i),
  .weekly_alarm_enable_i(weekly_alarm_enable_i),
  .weekly_alarm_clear_i(weekly_alarm_clear_i), .seconds_o(seconds_o),
  .second_tick_o(second_tick_o),
  .weekly_alarm_flag_o(weekly_alarm_flag_o),
  .interrupt_out_n_o(interrupt_out_n_o));
`default_nettype wire
